// ===== qst_pkg.sv
package qst_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus carrier and register map.

  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

  localparam logic [ADDR_W-1:0] OFS_CONTROL     = 2'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS_CTRL = 2'h1;
  localparam logic [ADDR_W-1:0] OFS_ALARM       = 2'h2;
  localparam logic [ADDR_W-1:0] OFS_COUNT       = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.

  localparam int unsigned CTRL_ON_BIT      = 7;
  localparam int unsigned CTRL_SRC_LSB     = 5;
  localparam int unsigned CTRL_RESTART_BIT = 4;
  localparam int unsigned CTRL_CLKO_BIT    = 3;
  localparam int unsigned CTRL_PS_LSB      = 0;
  localparam int unsigned STAT_FLAG_LSB    = 5;
  localparam int unsigned STAT_IE_LSB      = 2;
  localparam int unsigned STAT_AFON_BIT    = 1;
  localparam int unsigned STAT_PEND_BIT    = 0;
  localparam int unsigned ALARM_VAL_LSB    = 2;

  // Flag index: 2 quarter tick, 1 whole second, 0 alarm.
  localparam int unsigned FLAG_QUARTER = 2;
  localparam int unsigned FLAG_SECOND  = 1;
  localparam int unsigned FLAG_ALARM   = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, modes and timing.

  typedef enum logic [1:0] {
    SRC_EXT_OSC  = 2'b00,
    SRC_LPO_1KHZ = 2'b01,
    SRC_INT_REF  = 2'b10,
    SRC_RESERVED = 2'b11
  } ref_src_e;

  typedef enum logic [0:0] {
    MW_IDLE = 1'b0,
    MW_BUSY = 1'b1
  } match_wr_e;

  localparam ref_src_e    RST_SRC          = SRC_EXT_OSC;
  localparam logic [2:0]  RST_PRESCALE     = 3'h1;
  localparam logic [1:0]  MATCH_APPLY_CYC  = 2'h2;

  // First stage divides the reference to the clock output rate.
  function automatic logic [8:0] pre_div(input logic [2:0] ps);
    case (ps)
      3'h4:    pre_div = 9'h080;
      3'h5:    pre_div = 9'h07d;
      3'h6:    pre_div = 9'h0fa;
      3'h7:    pre_div = 9'h1f4;
      default: pre_div = 9'h001;
    endcase
  endfunction : pre_div

  // Second stage divides the clock output rate down to 4 Hz.
  function automatic logic [13:0] base_div(input logic [2:0] ps);
    case (ps)
      3'h0:    base_div = 14'h00fa;
      3'h1:    base_div = 14'h2000;
      3'h3:    base_div = 14'h2580;
      3'h4:    base_div = 14'h2580;
      default: base_div = 14'h1f40;
    endcase
  endfunction : base_div

endpackage : qst_pkg

// ===== quarter_second_timekeeper.sv
// Local design decisions: the plain strobed port and the register offsets.
module quarter_second_timekeeper
  import qst_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        external_osc_clock,
  input  wire logic        low_power_1khz_osc,
  input  wire logic        internal_ref_clock,
  input  wire reg_req_s    reg_req,
  output logic [DATA_W-1:0] rd_data,
  output logic             irq,
  output logic             divided_clock_out,
  output logic             alarm_pulse_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release.

  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic            module_on_r;
  ref_src_e        ref_clock_select_r;
  logic            clock_out_on_r;
  logic [2:0]      prescale_select_r;
  logic [2:0]      irq_on_r;
  logic            alarm_function_on_r;
  logic [2:0]      flag_r;
  logic [2:0]      flag_set;
  logic [5:0]      alarm_value_r;
  logic [1:0]      alarm_low_bits_r;
  logic [5:0]      alarm_shadow_r;
  match_wr_e       mw_state_r;
  logic [1:0]      mw_wait_r;
  logic            alarm_write_pending;
  logic [7:0]      quarter_count_r;
  logic [7:0]      count_inc;
  logic [8:0]      div1_r;
  logic [13:0]     div2_r;
  logic            ref_now;
  logic            ref_prev_r;
  logic            ref_edge;
  logic            pre_tick;
  logic            tick;
  logic            div_clear;
  logic            match_hit;
  logic            clk_out_nxt;
  logic            wr_ctrl;
  logic            wr_stat;
  logic            wr_alarm;
  logic            restart;
  logic [DATA_W-1:0] rd_data_r;
  logic            irq_r;
  logic            div_out_r;
  logic            alarm_pulse_r;

  assign wr_ctrl  = reg_req.wr && (reg_req.addr == OFS_CONTROL);
  assign wr_stat  = reg_req.wr && (reg_req.addr == OFS_STATUS_CTRL);
  assign wr_alarm = reg_req.wr && (reg_req.addr == OFS_ALARM);
  assign restart  = wr_ctrl && reg_req.wdata[CTRL_RESTART_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      module_on_r        <= 1'b0;
      ref_clock_select_r <= RST_SRC;
      clock_out_on_r     <= 1'b0;
      prescale_select_r  <= RST_PRESCALE;
    end else if (wr_ctrl) begin
      module_on_r        <= reg_req.wdata[CTRL_ON_BIT];
      ref_clock_select_r <= ref_src_e'(reg_req.wdata[CTRL_SRC_LSB +: 2]);
      clock_out_on_r     <= reg_req.wdata[CTRL_CLKO_BIT];
      prescale_select_r  <= reg_req.wdata[CTRL_PS_LSB +: 3];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_on_r            <= 3'h0;
      alarm_function_on_r <= 1'b0;
    end else if (wr_stat) begin
      irq_on_r            <= reg_req.wdata[STAT_IE_LSB +: 3];
      alarm_function_on_r <= reg_req.wdata[STAT_AFON_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference selection and two-stage prescaler.

  always_comb begin
    case (ref_clock_select_r)
      SRC_EXT_OSC:  ref_now = external_osc_clock;
      SRC_LPO_1KHZ: ref_now = low_power_1khz_osc;
      SRC_INT_REF:  ref_now = internal_ref_clock;
      default:      ref_now = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_prev_r <= 1'b0;
    end else begin
      ref_prev_r <= ref_now;
    end
  end

  assign ref_edge  = ref_now && !ref_prev_r;
  assign div_clear = !module_on_r || restart;
  assign pre_tick  = ref_edge && (div1_r == 9'(pre_div(prescale_select_r) - 9'h1));
  assign tick      = pre_tick && !div_clear
                     && (div2_r == 14'(base_div(prescale_select_r) - 14'h1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div1_r <= 9'h000;
    end else if (div_clear) begin
      div1_r <= 9'h000;
    end else if (ref_edge) begin
      div1_r <= pre_tick ? 9'h000 : 9'(div1_r + 9'h1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div2_r <= 14'h0000;
    end else if (div_clear) begin
      div2_r <= 14'h0000;
    end else if (pre_tick) begin
      div2_r <= tick ? 14'h0000 : 14'(div2_r + 14'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-second counter and match.

  assign count_inc = 8'(quarter_count_r + 8'h01);
  assign match_hit = tick && alarm_function_on_r
                     && (count_inc == {alarm_value_r, alarm_low_bits_r});

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quarter_count_r <= 8'h00;
    end else if (div_clear) begin
      quarter_count_r <= 8'h00;
    end else if (match_hit) begin
      quarter_count_r <= {6'h00, count_inc[1:0]};
    end else if (tick) begin
      quarter_count_r <= count_inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: a set in the same cycle as a write-one clear wins.

  assign flag_set[FLAG_QUARTER] = tick;
  assign flag_set[FLAG_SECOND]  = tick && (count_inc[1:0] == 2'b00);
  assign flag_set[FLAG_ALARM]   = match_hit;

  for (genvar i = 0; i < 3; i++) begin : g_flag
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        flag_r[i] <= 1'b0;
      end else if (flag_set[i]) begin
        flag_r[i] <= 1'b1;
      end else if (wr_stat && reg_req.wdata[STAT_FLAG_LSB + i]) begin
        flag_r[i] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm value write path.

  assign alarm_write_pending = (mw_state_r == MW_BUSY);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mw_state_r       <= MW_IDLE;
      mw_wait_r        <= 2'h0;
      alarm_shadow_r   <= 6'h00;
      alarm_value_r    <= 6'h00;
      alarm_low_bits_r <= 2'h0;
    end else begin
      case (mw_state_r)
        MW_IDLE: begin
          if (wr_alarm) begin
            alarm_shadow_r <= reg_req.wdata[ALARM_VAL_LSB +: 6];
            mw_wait_r      <= 2'(MATCH_APPLY_CYC - 2'h1);
            mw_state_r     <= MW_BUSY;
          end
        end
        MW_BUSY: begin
          if (mw_wait_r == 2'h0) begin
            alarm_value_r    <= alarm_shadow_r;
            alarm_low_bits_r <= quarter_count_r[1:0];
            mw_state_r       <= MW_IDLE;
          end else begin
            mw_wait_r <= 2'(mw_wait_r - 2'h1);
          end
        end
        default: begin
          mw_state_r <= MW_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  always_comb begin
    if (prescale_select_r == 3'h0) begin
      clk_out_nxt = 1'b0;
    end else if (pre_div(prescale_select_r) == 9'h001) begin
      clk_out_nxt = ref_now;
    end else begin
      clk_out_nxt = div1_r < (pre_div(prescale_select_r) >> 1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_out_r     <= 1'b0;
      alarm_pulse_r <= 1'b0;
      irq_r         <= 1'b0;
    end else begin
      div_out_r     <= clock_out_on_r && clk_out_nxt;
      alarm_pulse_r <= match_hit;
      irq_r         <= |(flag_r & irq_on_r);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        OFS_CONTROL:     rd_data_r <= {module_on_r, ref_clock_select_r, 1'b0,
                                       clock_out_on_r, prescale_select_r};
        OFS_STATUS_CTRL: rd_data_r <= {flag_r, irq_on_r, alarm_function_on_r, alarm_write_pending};
        OFS_ALARM:       rd_data_r <= {alarm_value_r, alarm_low_bits_r};
        OFS_COUNT:       rd_data_r <= quarter_count_r;
        default:         rd_data_r <= 8'h00;
      endcase
    end else begin
      rd_data_r <= 8'h00;
    end
  end

  assign rd_data           = rd_data_r;
  assign irq               = irq_r;
  assign divided_clock_out = div_out_r;
  assign alarm_pulse_out   = alarm_pulse_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_off_holds_zero: assert property (!module_on_r |=> quarter_count_r == 8'h00)
    else $error("Counter not held at zero while module off.");

  chk_restart_clears: assert property (restart |=> quarter_count_r == 8'h00 && div1_r == 9'h000
                                       && div2_r == 14'h0000)
    else $error("Restart did not clear counter and divider.");

  chk_restart_reads_zero: assert property (reg_req.rd && reg_req.addr == OFS_CONTROL
                                           |=> !rd_data[CTRL_RESTART_BIT])
    else $error("Restart bit read back as one.");

  chk_clock_out_gate: assert property (!clock_out_on_r |=> !divided_clock_out)
    else $error("Divided clock driven while output disabled.");

  chk_quarter_flag_set: assert property (tick |=> flag_r[FLAG_QUARTER])
    else $error("Quarter flag not set on increment.");

  chk_second_flag_set: assert property (tick && count_inc[1:0] == 2'b00
                                        |=> flag_r[FLAG_SECOND] && quarter_count_r[1:0] == 2'b00)
    else $error("Second flag not set on fourth increment.");

  chk_match_resets_upper: assert property (match_hit |=> quarter_count_r[7:2] == 6'h00
                                           && flag_r[FLAG_ALARM] && alarm_pulse_out)
    else $error("Match did not clear upper bits or raise flag and pulse.");

  chk_no_match_disabled: assert property (!alarm_function_on_r |=> !alarm_pulse_out)
    else $error("Match pulse while alarm function off.");

  chk_write_pending_span: assert property (wr_alarm && !alarm_write_pending
                                           |=> alarm_write_pending [*2] ##1 !alarm_write_pending)
    else $error("Write pending bit span wrong.");

  chk_second_write_dropped: assert property (wr_alarm && alarm_write_pending
                                             |=> $stable(alarm_shadow_r))
    else $error("Alarm write accepted while pending.");

  chk_irq_follows_flags: assert property (|(flag_r & irq_on_r) |=> irq)
    else $error("Interrupt missing for enabled flag.");

  chk_irq_quiet: assert property (!(|(flag_r & irq_on_r)) |=> !irq)
    else $error("Interrupt without enabled flag.");

  cov_match_hit:       cover property (match_hit ##1 alarm_pulse_out);
  cov_second_tick:     cover property (tick && count_inc[1:0] == 2'b00);
  cov_write_collision: cover property (wr_alarm && alarm_write_pending);
  cov_count_wrap:      cover property (tick && quarter_count_r == 8'hff);

endmodule : quarter_second_timekeeper

// ===== quarter_second_timekeeper_tb.sv
module quarter_second_timekeeper_tb import qst_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic             clk;
  logic             arst_n;
  logic             external_osc_clock = 1'b0;
  logic             low_power_1khz_osc = 1'b0;
  logic             internal_ref_clock = 1'b0;
  reg_req_s         reg_req;
  logic [DATA_W-1:0] rd_data;
  logic             irq;
  logic             divided_clock_out;
  logic             alarm_pulse_out;
  logic [1:0]       ref_sel;
  logic [1:0]       ph = 2'h0;
  logic [7:0]       got;
  logic [7:0]       ps;
  logic [2:0]       s;
  logic             p;
  int               fail_count;
  int               n_checks;
  int               cycles = 0;
  int               k;
  int               divs [4] = '{128, 125, 250, 500};

  quarter_second_timekeeper quarter_second_timekeeper_inst (
    .clk                (clk),
    .arst_n             (arst_n),
    .external_osc_clock (external_osc_clock),
    .low_power_1khz_osc (low_power_1khz_osc),
    .internal_ref_clock (internal_ref_clock),
    .reg_req            (reg_req),
    .rd_data            (rd_data),
    .irq                (irq),
    .divided_clock_out  (divided_clock_out),
    .alarm_pulse_out    (alarm_pulse_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, references and run limit.

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // The selected reference rises once every four cycles; select 3 runs all three.
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    external_osc_clock <= ph[1] && (ref_sel == 2'h0 || ref_sel == 2'h3);
    low_power_1khz_osc <= ph[1] && (ref_sel == 2'h1 || ref_sel == 2'h3);
    internal_ref_clock <= ph[1] && (ref_sel == 2'h2 || ref_sel == 2'h3);
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access tasks.

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    n_checks++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req <= '0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [1:0] a);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req <= '0;
    @(negedge clk);
    got = rd_data;
    @(posedge clk);
  endtask : rd

  task automatic rdc(input logic [1:0] a, input logic [7:0] exp, input string name);
    rd(a);
    chk(name, {8'h00, exp}, {8'h00, got});
  endtask : rdc

  // Looks at the registered interrupt in mid-cycle, after the edge that launched it has settled.
  task automatic chk_irq(input string name, input logic exp);
    @(negedge clk);
    chk(name, {15'h0, exp}, {15'h0, irq});
    @(posedge clk);
  endtask : chk_irq

  task automatic wait_cnt(input logic [7:0] v);
    int i;
    for (i = 0; i < 3000; i++) begin
      rd(OFS_COUNT);
      if (got === v) return;
    end
    chk("count wait", {8'h00, v}, {8'h00, got});
  endtask : wait_cnt

  task automatic period(input int exp);
    int n;
    int c;
    logic q;
    n = 0;
    c = 0;
    q = divided_clock_out;
    while (n < 2 && c < 5000) begin
      @(negedge clk);
      c++;
      if (divided_clock_out === 1'b1 && q === 1'b0) begin
        n++;
        if (n == 1) c = 0;
      end
      q = divided_clock_out;
    end
    chk("clock out period", exp[15:0], c[15:0]);
    @(posedge clk);
  endtask : period

  task automatic conclude();
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence.

  initial begin
    arst_n = 1'b0;
    reg_req = '0;
    ref_sel = 2'h1;
    fail_count = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(OFS_CONTROL, 8'h01, "control reset");
    rdc(OFS_STATUS_CTRL, 8'h00, "status reset");
    rdc(OFS_ALARM, 8'h00, "alarm reset");
    rdc(OFS_COUNT, 8'h00, "count reset");
    for (s = 3'h0; s < 3'h4; s++) begin
      ref_sel <= s[1:0];
      wr(OFS_CONTROL, {1'b0, s[1:0], 5'h00});
      wr(OFS_CONTROL, {1'b1, s[1:0], 5'h00});
      repeat (1100) @(posedge clk);
      rdc(OFS_COUNT, (s == 3'h3) ? 8'h00 : 8'h01, "count per source");
      wr(OFS_CONTROL, 8'h00);
      rdc(OFS_COUNT, 8'h00, "count when off");
    end
    ref_sel <= 2'h1;
    wr(OFS_CONTROL, 8'h20);
    wr(OFS_STATUS_CTRL, 8'he0);
    repeat (1100) @(posedge clk);
    rdc(OFS_COUNT, 8'h00, "no count while off");
    rdc(OFS_STATUS_CTRL, 8'h00, "no flags while off");
    wr(OFS_CONTROL, 8'ha0);
    wait_cnt(8'h01);
    rdc(OFS_STATUS_CTRL, 8'h80, "quarter flag");
    chk_irq("irq masked", 1'b0);
    wr(OFS_STATUS_CTRL, 8'h10);
    chk_irq("irq quarter", 1'b1);
    wr(OFS_STATUS_CTRL, 8'h90);
    rdc(OFS_STATUS_CTRL, 8'h10, "quarter clear");
    chk_irq("irq cleared", 1'b0);
    wait_cnt(8'h03);
    rdc(OFS_STATUS_CTRL, 8'h90, "no second yet");
    wait_cnt(8'h04);
    rdc(OFS_STATUS_CTRL, 8'hd0, "second flag");
    wr(OFS_STATUS_CTRL, 8'he0);
    wr(OFS_CONTROL, 8'hb0);
    rdc(OFS_CONTROL, 8'ha0, "restart reads zero");
    rdc(OFS_COUNT, 8'h00, "restart clears");
    wait_cnt(8'h01);
    reg_req <= '{addr: OFS_ALARM, wdata: 8'h08, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req <= '{addr: OFS_ALARM, wdata: 8'h0c, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    rdc(OFS_STATUS_CTRL, 8'h81, "write pending");
    rdc(OFS_STATUS_CTRL, 8'h80, "write done");
    rdc(OFS_ALARM, 8'h09, "alarm value");
    wr(OFS_STATUS_CTRL, 8'h86);
    k = 0;
    while (alarm_pulse_out !== 1'b1 && k < 9000) begin
      @(negedge clk);
      k++;
    end
    chk("alarm pulse", 16'h1, {15'h0, alarm_pulse_out});
    @(posedge clk);
    rdc(OFS_COUNT, 8'h01, "count after match");
    rdc(OFS_STATUS_CTRL, 8'he6, "alarm flag");
    chk_irq("irq alarm", 1'b1);
    wr(OFS_STATUS_CTRL, 8'h02);
    chk_irq("irq alarm masked", 1'b0);
    wr(OFS_STATUS_CTRL, 8'he0);
    rdc(OFS_STATUS_CTRL, 8'h00, "flags cleared");
    ref_sel <= 2'h0;
    for (ps = 8'h01; ps < 8'h08; ps++) begin
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_CONTROL, 8'h08 | ps);
      wr(OFS_CONTROL, 8'h88 | ps);
      if (ps < 8'h04) begin
        @(negedge clk);
        p = external_osc_clock;
        repeat (12) begin
          @(negedge clk);
          chk("clock out follow", {15'h0, p}, {15'h0, divided_clock_out});
          p = external_osc_clock;
        end
        @(posedge clk);
        wr(OFS_CONTROL, 8'h80 | ps);
        repeat (12) begin
          @(negedge clk);
          chk("clock out off", 16'h0, {15'h0, divided_clock_out});
        end
        @(posedge clk);
      end else begin
        period(divs[ps - 8'h04] * 4);
      end
    end
    wr(OFS_CONTROL, 8'h00);
    conclude();
  end

endmodule : quarter_second_timekeeper_tb
